// File: src/adccs_top.sv
// capture sequencer: initiation dialog, sampling, packing and host transfer
// Function
// [RULE1] pulse attention while units on and gate active
// [RULE2] host prepares buffer then acknowledges attention
// [RULE3] host watchdog reports missing attention
// [RULE4] start on pushbutton or external trigger
// [RULE5] convert pulses from selected divider tap
// [RULE6] latch converter word on conversion-done strobe
// [RULE7] convert until counter or host ends run
// [RULE8] transfer buffered words after or during conversion
// [RULE9] pack three samples into each word
// [RULE10] put word on lines, raise offer
// [RULE11] host accepts only after storing word
// [RULE12] drop offer on accept, repeat per word
// [RULE13] late accept sets sticky word error flags
// [RULE14] runout expiry drops offer, awaits reset
// [RULE15] host ends exchange, unpacks three samples
// [RULE16] host discards cycle on flagged word
// [RULE17] reset by pushbutton or listen gate rise
// [RULE18] after reset redo attention exchange
// [RULE19] word is 30 bits: 27 data, 3 flags
// [RULE20] hold line and data until acknowledged
// [RULE21] at least 1.2 us low between offers
// [RULE22] reset clears error, counter and timer
// [RULE23] count limit and runout fixed during cycle
//
// The address-and-strobe port and the register offsets were decided locally.
module adccs_top (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        clk_en_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic [3:0]  units_on_i,
  input  wire logic        host_listen_gate_i,
  input  wire logic        host_accept_line_i,
  input  wire logic        start_btn_i,
  input  wire logic        reset_btn_i,
  input  wire logic        ext_trig_i,
  input  wire logic [8:0]  adc_data_i,
  input  wire logic        adc_eoc_i,
  output logic             adc_convert_o,
  output logic             host_attention_o,
  output logic             word_offer_flag_o,
  output logic      [29:0] host_data_o
);

  adccs_pkg::adccs_state_t r;
  adccs_pkg::adccs_state_t n;

  logic [adccs_pkg::PIN_W-1:0]  pins;
  logic [adccs_pkg::WORD_W-4:0] mem [adccs_pkg::BUF_DEPTH];
  logic                         mem_we;
  logic [26:0]                  mem_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // every pin passes two flops; data travels with its strobe
  adccs_sync #(
    .W (adccs_pkg::PIN_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .clk_en_i   (clk_en_i),
    .d_i        ({adc_data_i, adc_eoc_i, ext_trig_i, reset_btn_i, start_btn_i,
                  host_accept_line_i, host_listen_gate_i, units_on_i}),
    .q_o        (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic [5:0]  rise;
  logic [5:0]  fall;
  logic        all_on;
  logic        acc_rise;
  logic        last;
  logic        wr_word;
  logic        rd_word;
  logic        cfg_ok;
  logic [26:0] word;
  localparam int unsigned DIV_W_L = adccs_pkg::DIV_W;

  logic [15:0] cnt_inc;
  logic [DIV_W_L-1:0] div_inc;

  always_comb begin
    n         = r;
    mem_we    = 1'b0;
    mem_wdata = '0;
    wr_word   = 1'b0;
    rd_word   = 1'b0;
    last      = 1'b0;
    word      = r.asm_word;
    cnt_inc   = r.smp_cnt + 16'h0001;
    div_inc   = r.div + 16'h0001;
    rise      = pins[9:4] & ~r.prev;
    fall      = ~pins[9:4] & r.prev;
    all_on    = &pins[adccs_pkg::UNITS_N-1:0];
    acc_rise  = rise[adccs_pkg::PIN_ACCEPT-4];
    n.prev    = pins[9:4];
    n.conv    = 1'b0;
    n.rdata   = '0;
    // settings change only between cycles
    cfg_ok    = (r.m == adccs_pkg::M_IDLE) || (r.m == adccs_pkg::M_HALT); // [RULE23]
    if (r.gap != 6'h00) begin
      n.gap = r.gap - 6'h01;
    end

    // register port
    if (reg_wr_i) begin
      if (reg_addr_i == adccs_pkg::OFF_CTRL) begin
        if (cfg_ok) begin
          n.tap        = reg_wdata_i[adccs_pkg::CTRL_TAP_LSB +: adccs_pkg::CTRL_TAP_W];
          n.auto_start = reg_wdata_i[adccs_pkg::CTRL_AUTO_START];
          n.auto_reset = reg_wdata_i[adccs_pkg::CTRL_AUTO_RESET];
        end
        if (reg_wdata_i[adccs_pkg::CTRL_HOST_END] && r.m == adccs_pkg::M_RUN) begin
          n.stop = 1'b1; // [RULE7]
        end
      end else if (reg_addr_i == adccs_pkg::OFF_LIMIT && cfg_ok) begin
        n.limit = reg_wdata_i[15:0]; // [RULE23]
      end else if (reg_addr_i == adccs_pkg::OFF_RUNOUT && cfg_ok) begin
        n.runout = reg_wdata_i; // [RULE23]
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == adccs_pkg::OFF_CTRL) begin
        n.rdata = {25'h000_0000, 1'b0, r.auto_reset, r.auto_start, r.tap};
      end else if (reg_addr_i == adccs_pkg::OFF_LIMIT) begin
        n.rdata = {16'h0000, r.limit};
      end else if (reg_addr_i == adccs_pkg::OFF_RUNOUT) begin
        n.rdata = r.runout;
      end else if (reg_addr_i == adccs_pkg::OFF_STATUS) begin
        n.rdata = {r.smp_cnt, 6'h00, r.err, r.x, r.m};
      end else begin
        n.rdata = '0;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    case (r.m)
      adccs_pkg::M_IDLE: begin
        if (all_on && pins[adccs_pkg::PIN_GATE] && r.gap == 6'h00) begin
          n.attn = 1'b1; // [RULE1]
          n.m    = adccs_pkg::M_ATTN;
        end
      end
      adccs_pkg::M_ATTN: begin
        // acknowledge is accept rising with the gate falling in one sample
        if (acc_rise && fall[adccs_pkg::PIN_GATE-4]) begin
          n.attn = 1'b0; // [RULE1]
          n.gap  = 6'(adccs_pkg::REQ_GAP_CYC);
          n.m    = adccs_pkg::M_ARMED;
        end else if (!(all_on && pins[adccs_pkg::PIN_GATE])) begin
          // lost enable: drop and retry later, so the attention repeats
          n.attn = 1'b0; // [RULE1]
          n.gap  = 6'(adccs_pkg::REQ_GAP_CYC);
          n.m    = adccs_pkg::M_IDLE;
        end
      end
      adccs_pkg::M_ARMED: begin
        if (r.auto_start ? rise[adccs_pkg::PIN_TRIG-4] : rise[adccs_pkg::PIN_START-4]) begin
          n.div = '0; // [RULE4]
          n.m   = adccs_pkg::M_RUN;
        end
      end
      adccs_pkg::M_RUN: begin
        n.div = div_inc;
        // one-cycle convert on each rising edge of the chosen tap
        n.conv = !r.div[r.tap] && div_inc[r.tap]; // [RULE5]
        last   = r.stop;
        if (rise[adccs_pkg::PIN_EOC-4]) begin
          n.smp_cnt = cnt_inc; // [RULE6]
          last      = r.stop || (cnt_inc >= r.limit); // [RULE7]
          word[9*r.slot +: 9] = pins[adccs_pkg::PIN_DATA +: adccs_pkg::SAMPLE_W]; // [RULE9]
          if (r.slot == 2'd2 || last) begin
            wr_word  = 1'b1;
            n.slot   = 2'd0;
            word     = word;
          end else begin
            n.slot = r.slot + 2'd1;
          end
        end else if (last && r.slot != 2'd0) begin
          // partial group is flushed with zero samples
          wr_word = 1'b1;
          n.slot  = 2'd0;
        end
        n.asm_word = wr_word ? 27'h000_0000 : word;
        if (last) begin
          n.stop = 1'b0;
          n.m    = adccs_pkg::M_DRAIN; // [RULE8]
        end
      end
      adccs_pkg::M_DRAIN: begin
        if (r.used == '0 && r.x == adccs_pkg::X_IDLE) begin
          n.m = adccs_pkg::M_HALT;
        end
      end
      adccs_pkg::M_HALT: begin
        if (r.auto_reset ? rise[adccs_pkg::PIN_GATE-4] : rise[adccs_pkg::PIN_RESET-4]) begin
          n.err      = 1'b0; // [RULE22]
          n.smp_cnt  = '0;
          n.tmo      = '0;
          n.wr_ptr   = '0;
          n.rd_ptr   = '0;
          n.used     = '0;
          n.slot     = 2'd0;
          n.asm_word = '0;
          n.x        = adccs_pkg::X_IDLE;
          n.offer    = 1'b0;
          n.gap      = 6'(adccs_pkg::REQ_GAP_CYC);
          n.m        = adccs_pkg::M_IDLE; // [RULE17] [RULE18]
        end
      end
      default: begin
        n.m = adccs_pkg::M_IDLE;
      end
    endcase

    // buffer write; an overrun loses a group and is flagged like a late accept
    if (wr_word) begin
      if (r.used == 9'(adccs_pkg::BUF_DEPTH)) begin
        n.err = 1'b1;
      end else begin
        mem_we    = 1'b1;
        mem_wdata = word;
        n.wr_ptr  = r.wr_ptr + 8'h01;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // host transfer, also during the run
    if (r.m == adccs_pkg::M_RUN || r.m == adccs_pkg::M_DRAIN) begin // [RULE8]
      case (r.x)
        adccs_pkg::X_IDLE: begin
          if (r.used != '0) begin
            rd_word  = 1'b1;
            n.x      = adccs_pkg::X_GAP; // [RULE10]
          end
        end
        adccs_pkg::X_GAP: begin
          if (acc_rise) begin
            // accept for the old word after the new one is on the lines
            n.err = 1'b1; // [RULE13]
          end else if (r.gap == 6'h00) begin
            n.offer = 1'b1; // [RULE10] [RULE21]
            n.tmo   = '0;
            n.x     = adccs_pkg::X_OFFER;
          end
        end
        adccs_pkg::X_OFFER: begin
          n.tmo = r.tmo + 32'h0000_0001;
          if (acc_rise) begin
            n.offer = 1'b0; // [RULE12]
            n.gap   = 6'(adccs_pkg::REQ_GAP_CYC); // [RULE21]
            n.x     = adccs_pkg::X_IDLE;
            if (r.used != '0) begin
              rd_word = 1'b1;
              n.x     = adccs_pkg::X_GAP;
            end
          end else if (r.tmo >= r.runout) begin
            // host buffer assumed full
            n.offer = 1'b0; // [RULE14]
            n.x     = adccs_pkg::X_IDLE;
            n.m     = adccs_pkg::M_HALT;
          end
        end
        default: begin
          n.x = adccs_pkg::X_IDLE;
        end
      endcase
    end
    if (rd_word) begin
      n.data[adccs_pkg::DATA_W-1:0] = mem[r.rd_ptr]; // [RULE19]
      n.rd_ptr = r.rd_ptr + 8'h01;
    end
    // flags track the sticky error on whatever word is on the lines
    n.data[adccs_pkg::WORD_W-1:adccs_pkg::FLAG_LSB] = {3{n.err}}; // [RULE13] [RULE19]
    n.used = r.used + 9'(mem_we) - 9'(rd_word);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      r <= adccs_pkg::ST_RST;
    end else if (clk_en_i) begin
      r <= n;
    end
  end

  // no reset needed: entries are read only after being written
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && mem_we) begin
      mem[r.wr_ptr] <= mem_wdata;
    end
  end

  assign reg_rdata_o       = r.rdata;
  assign adc_convert_o     = r.conv;
  assign host_attention_o  = r.attn;
  assign word_offer_flag_o = r.offer;
  assign host_data_o       = r.data;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [5:0] chk_low;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      chk_low <= '0;
    end else if (clk_en_i) begin
      if (r.offer) begin
        chk_low <= '0;
      end else if (chk_low != 6'h3F) begin
        chk_low <= chk_low + 6'h01;
      end
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  chk_attn_cause: assert property ($rose(r.attn) |-> $past(all_on && pins[4])) // [RULE1]
    else $error("attention raised without units on and gate");
  chk_start_src: assert property (clk_en_i && r.m == adccs_pkg::M_ARMED
      && n.m == adccs_pkg::M_RUN |-> (r.auto_start ? rise[4] : rise[2])) // [RULE4]
    else $error("run started by wrong source");
  chk_conv_run: assert property ($rose(r.conv) |-> $past(r.m == adccs_pkg::M_RUN)) // [RULE5]
    else $error("convert pulse outside run");
  chk_eoc_count: assert property (clk_en_i && r.m == adccs_pkg::M_RUN && rise[5]
      |=> r.smp_cnt == $past(r.smp_cnt) + 16'h0001) // [RULE6]
    else $error("sample not counted on conversion done");
  chk_offer_hold: assert property (clk_en_i && r.offer && !acc_rise && r.tmo < r.runout
      |=> r.offer && $stable(r.data[26:0])) // [RULE20]
    else $error("offer or data changed before accept");
  chk_accept_drop: assert property (clk_en_i && r.offer && acc_rise |=> !r.offer) // [RULE12]
    else $error("offer not dropped after accept");
  chk_offer_gap: assert property ($rose(r.offer) |-> chk_low >= 6'(adccs_pkg::REQ_GAP_CYC)) // [RULE21]
    else $error("offer low time too short");
  chk_err_sticky: assert property (r.err && r.m != adccs_pkg::M_HALT |=> r.err) // [RULE13]
    else $error("error flag cleared during cycle");
  chk_err_bits: assert property (r.offer && r.err |-> r.data[29:27] == 3'h7) // [RULE13]
    else $error("offered word lacks error flags");
  chk_runout_halt: assert property (clk_en_i && r.x == adccs_pkg::X_OFFER && !acc_rise
      && r.tmo >= r.runout |=> !r.offer && r.m == adccs_pkg::M_HALT) // [RULE14]
    else $error("runout did not end transfer");
  chk_reset_clear: assert property (r.m == adccs_pkg::M_IDLE
      && $past(r.m) == adccs_pkg::M_HALT |-> !r.err && r.smp_cnt == 16'h0000) // [RULE22]
    else $error("reset left stale state");

endmodule

// File: src/adccs_pkg.sv
// constants, types and reset values shared by the capture sequencer
package adccs_pkg;

  // timing at 25 MHz
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned REQ_GAP_NS    = 1200;
  localparam int unsigned REQ_GAP_CYC   = (REQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // data layout
  localparam int unsigned SAMPLE_W = 9;
  localparam int unsigned PACK_N   = 3;
  localparam int unsigned DATA_W   = 27;
  localparam int unsigned WORD_W   = 30;
  localparam int unsigned FLAG_LSB = 27;
  localparam int unsigned UNITS_N  = 4;

  // sample buffer
  localparam int unsigned BUF_DEPTH = 256;
  localparam int unsigned PTR_W     = 8;

  // divider chain
  localparam int unsigned DIV_W = 16;

  // register port
  localparam int unsigned ADDR_W     = 4;
  localparam logic [3:0]  OFF_CTRL   = 4'h0;
  localparam logic [3:0]  OFF_LIMIT  = 4'h4;
  localparam logic [3:0]  OFF_RUNOUT = 4'h8;
  localparam logic [3:0]  OFF_STATUS = 4'hC;

  // control fields
  localparam int unsigned CTRL_TAP_LSB    = 0;
  localparam int unsigned CTRL_TAP_W      = 4;
  localparam int unsigned CTRL_AUTO_START = 4;
  localparam int unsigned CTRL_AUTO_RESET = 5;
  localparam int unsigned CTRL_HOST_END   = 6;

  // status fields
  localparam int unsigned STAT_MAIN_LSB = 0;
  localparam int unsigned STAT_XFER_LSB = 6;
  localparam int unsigned STAT_ERR      = 9;
  localparam int unsigned STAT_CNT_LSB  = 16;

  // reset values
  localparam logic [3:0]  CTRL_TAP_RST = 4'h3;
  localparam logic [15:0] LIMIT_RST    = 16'h0300;
  localparam logic [31:0] RUNOUT_RST   = 32'h0001_86A0;

  // synchronised pin vector layout
  localparam int unsigned PIN_GATE   = 4;
  localparam int unsigned PIN_ACCEPT = 5;
  localparam int unsigned PIN_START  = 6;
  localparam int unsigned PIN_RESET  = 7;
  localparam int unsigned PIN_TRIG   = 8;
  localparam int unsigned PIN_EOC    = 9;
  localparam int unsigned PIN_DATA   = 10;
  localparam int unsigned PIN_W      = 19;

  typedef enum logic [5:0] {
    M_IDLE  = 6'h01,
    M_ATTN  = 6'h02,
    M_ARMED = 6'h04,
    M_RUN   = 6'h08,
    M_DRAIN = 6'h10,
    M_HALT  = 6'h20
  } adccs_main_t;

  typedef enum logic [2:0] {
    X_IDLE  = 3'h1,
    X_GAP   = 3'h2,
    X_OFFER = 3'h4
  } adccs_xfer_t;

  typedef struct packed {
    adccs_main_t       m;
    adccs_xfer_t       x;
    logic [3:0]        tap;
    logic              auto_start;
    logic              auto_reset;
    logic [15:0]       limit;
    logic [31:0]       runout;
    logic [DIV_W-1:0]  div;
    logic [15:0]       smp_cnt;
    logic [1:0]        slot;
    logic [26:0]       asm_word;
    logic [PTR_W-1:0]  wr_ptr;
    logic [PTR_W-1:0]  rd_ptr;
    logic [PTR_W:0]    used;
    logic [5:0]        gap;
    logic [31:0]       tmo;
    logic              err;
    logic              stop;
    logic [5:0]        prev;
    logic              conv;
    logic              attn;
    logic              offer;
    logic [29:0]       data;
    logic [31:0]       rdata;
  } adccs_state_t;

  localparam adccs_state_t ST_RST = '{
    m:          M_IDLE,
    x:          X_IDLE,
    tap:        CTRL_TAP_RST,
    limit:      LIMIT_RST,
    runout:     RUNOUT_RST,
    default:    '0
  };

endpackage

// File: src/adccs_sync.sv
// two-flop synchroniser for a vector of pin inputs
module adccs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         clk_en_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } adccs_sync_state_t;

  adccs_sync_state_t sync_reg;
  adccs_sync_state_t sync_next;

  // first stage feeds only the second stage
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = d_i;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sync_reg <= '0;
    end else if (clk_en_i) begin
      sync_reg <= sync_next;
    end
  end

  assign q_o = sync_reg.s2;

endmodule

// File: verification/adccs_host_model.sv
// host input channel and converter model facing the capture sequencer
module adccs_host_model (
  input  wire logic        core_clk_i,
  input  wire logic        listen_i,
  input  wire logic        mute_i,
  input  wire logic        late_i,
  input  wire logic        attention_i,
  input  wire logic        offer_i,
  input  wire logic        convert_i,
  input  wire logic [29:0] data_i,
  output logic             gate_o,
  output logic             accept_o,
  output logic             eoc_o,
  output logic      [8:0]  adc_data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [29:0] words [0:31];
  int          nwords = 0;
  int          wait_c = 0;
  int          hold_c = 0;
  int          late_c = 0;
  int          adc_c  = 0;
  int          wd_c   = 0;
  int          wd_err = 0;
  int          bad_n  = 0;
  logic [8:0]  idx    = '0;

  initial begin
    gate_o     = 1'b0;
    accept_o   = 1'b0;
    eoc_o      = 1'b0;
    adc_data_o = '0;
  end

  ////////////////////////////////////////
  always @(posedge core_clk_i) begin
    if (listen_i)
      gate_o <= 1'b1;
    // watchdog: gate up with no attention counts an error
    if (gate_o && !attention_i) begin
      wd_c <= (wd_c == 99) ? 0 : wd_c + 1;
      if (wd_c == 99)
        wd_err <= wd_err + 1;
    end else
      wd_c <= 0;
    // converter: word set at convert, inverted after done so stale reads show
    if (convert_i) begin
      adc_c      <= 9;
      adc_data_o <= 9'h1A0 + idx;
      idx        <= idx + 9'h001;
    end else if (adc_c > 0)
      adc_c <= adc_c - 1;
    eoc_o <= (adc_c >= 2) && (adc_c <= 4);
    if (adc_c == 1)
      adc_data_o <= ~adc_data_o;
    // host side; late mode breaks the hold time on purpose
    if (accept_o) begin
      hold_c <= hold_c - 1;
      if (hold_c == 1)
        accept_o <= 1'b0;
    end else if (late_c > 0) begin
      late_c <= late_c - 1;
      if (late_c == 1) begin
        accept_o <= 1'b1;
        hold_c   <= 8;
      end
    end else if ((attention_i && gate_o) || (offer_i && !mute_i)) begin
      wait_c <= wait_c + 1;
      if (wait_c == 60) begin  // buffer set up first
        wait_c   <= 0;
        accept_o <= 1'b1;
        hold_c   <= late_i ? 8 : 56;
        late_c   <= late_i ? 4 : 0;
        if (attention_i) begin
          gate_o <= 1'b0;
          idx    <= '0;
        end else begin
          words[nwords] <= data_i;  // stored before accept
          nwords        <= nwords + 1;
          if (data_i[29:27] != 3'h0)
            bad_n <= bad_n + 1;  // flagged word: cycle to be dropped
        end
      end
    end else
      wait_c <= 0;
  end
endmodule

// File: verification/tb.sv
// self-checking bench for the capture sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        we;
    logic [3:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } adccs_row_t;

  logic        core_clk_i = 1'b0;
  logic        nrst_i     = 1'b0;
  logic [3:0]  addr       = '0;
  logic [31:0] wdata      = '0;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [3:0]  units      = 4'h7;
  logic [2:0]  btn        = '0;
  logic        listen     = 1'b0;
  logic        mute       = 1'b0;
  logic        late       = 1'b0;
  logic [31:0] rdata;
  logic        gate;
  logic        acc;
  logic        eoc;
  logic        conv;
  logic        attn;
  logic        offer;
  logic        prev_o     = 1'b0;
  logic [8:0]  adcd;
  logic [29:0] hdata;
  logic [29:0] prev_d     = '0;
  int          failures   = 0;
  int          checks     = 0;
  int          cyc        = 0;
  int          conv_n     = 0;
  int          conv_gap   = 0;
  int          last_conv  = 0;
  int          low_c      = 0;
  int          hi_c       = 0;
  adccs_row_t  rows [0:8] = '{
    '{1'b0, adccs_pkg::OFF_CTRL, '0, 32'(adccs_pkg::CTRL_TAP_RST)},
    '{1'b0, adccs_pkg::OFF_LIMIT, '0, 32'(adccs_pkg::LIMIT_RST)},
    '{1'b0, adccs_pkg::OFF_RUNOUT, '0, adccs_pkg::RUNOUT_RST},
    '{1'b0, adccs_pkg::OFF_STATUS, '0, 32'h0000_0041},
    '{1'b1, 4'h2, 32'hFFFF_FFFF, '0},
    '{1'b1, adccs_pkg::OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0041},
    '{1'b1, adccs_pkg::OFF_LIMIT, 32'h0000_0006, 32'h0000_0006},
    '{1'b1, adccs_pkg::OFF_RUNOUT, 32'h0000_00C8, 32'h0000_00C8},
    '{1'b1, adccs_pkg::OFF_CTRL, 32'h0000_0003, 32'h0000_0003}
  };

  adccs_top u_adccs_top (
    .core_clk_i         (core_clk_i),
    .nrst_i             (nrst_i),
    .clk_en_i           (1'b1),
    .reg_addr_i         (addr),
    .reg_wdata_i        (wdata),
    .reg_wr_i           (wr),
    .reg_rd_i           (rd),
    .reg_rdata_o        (rdata),
    .units_on_i         (units),
    .host_listen_gate_i (gate),
    .host_accept_line_i (acc),
    .start_btn_i        (btn[0]),
    .reset_btn_i        (btn[1]),
    .ext_trig_i         (btn[2]),
    .adc_data_i         (adcd),
    .adc_eoc_i          (eoc),
    .adc_convert_o      (conv),
    .host_attention_o   (attn),
    .word_offer_flag_o  (offer),
    .host_data_o        (hdata)
  );

  adccs_host_model u_adccs_host_model (
    .core_clk_i  (core_clk_i),
    .listen_i    (listen),
    .mute_i      (mute),
    .late_i      (late),
    .attention_i (attn),
    .offer_i     (offer),
    .convert_i   (conv),
    .data_i      (hdata),
    .gate_o      (gate),
    .accept_o    (acc),
    .eoc_o       (eoc),
    .adc_data_o  (adcd)
  );

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////
  task automatic final_report();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] q);
    @(posedge core_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask

  // polls status until the main state matches, then compares err, xfer and main
  task automatic wait_stat(input logic [9:0] e);
    logic [31:0] q;
    for (int n = 0; n < 3000; n++) begin
      rd_reg(adccs_pkg::OFF_STATUS, q);
      if (q[5:0] === e[5:0])
        break;
    end
    check({22'h00_0000, q[9:0]}, {22'h00_0000, e});
  endtask

  // buttons pass two sync flops, so hold them several cycles
  task automatic press(input int b);
    @(posedge core_clk_i);
    btn[b] <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    btn <= '0;
    repeat (4) @(posedge core_clk_i);
  endtask

  task automatic pulse_listen();
    @(posedge core_clk_i);
    listen <= 1'b1;
    @(posedge core_clk_i);
    listen <= 1'b0;
  endtask

  task automatic wait_words(input int n);
    for (int i = 0; i < 3000 && u_adccs_host_model.nwords < n; i++)
      @(posedge core_clk_i);
  endtask

  function automatic logic [31:0] wexp(input int n, input logic [2:0] f, input int k);
    logic [29:0] w;
    w = {f, 27'h000_0000};
    for (int i = 0; i < k; i++)
      w[9*i +: 9] = 9'h1A0 + 9'(n + i);
    return {2'b00, w};
  endfunction

  function automatic logic [31:0] word(input int i);
    return {2'b00, u_adccs_host_model.words[i]};
  endfunction

  ////////////////////////////////////////
  // monitors on the falling edge, where registered outputs have settled
  always @(negedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      final_report();
    end
    if (conv) begin
      conv_gap  = cyc - last_conv;
      last_conv = cyc;
      conv_n++;
    end
    if (offer && !prev_o)
      check(32'(low_c >= adccs_pkg::REQ_GAP_CYC), 32'h0000_0001);
    if (offer && prev_o)
      check({2'b00, hdata}, {2'b00, prev_d});
    hi_c   = offer ? (prev_o ? hi_c + 1 : 1) : hi_c;
    low_c  = offer ? 0 : low_c + 1;
    prev_o = offer;
    prev_d = hdata;
  end

  ////////////////////////////////////////
  initial begin
    logic [31:0] q;
    int          b;
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    foreach (rows[i]) begin
      if (rows[i].we)
        wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, q);
      check(q, rows[i].e);
    end
    // one unit still off: no attention despite the gate
    pulse_listen();
    repeat (200) @(negedge core_clk_i);
    check(32'(attn), 32'h0000_0000);
    check(32'(u_adccs_host_model.wd_err > 0), 32'h0000_0001);
    units <= 4'hF;
    wait_stat(10'h044);
    repeat (2) @(negedge core_clk_i);
    check(32'(attn), 32'h0000_0000);
    wr_reg(adccs_pkg::OFF_LIMIT, 32'h0000_0055);
    rd_reg(adccs_pkg::OFF_LIMIT, q);
    check(q, 32'h0000_0006);
    b = conv_n;
    repeat (100) @(negedge core_clk_i);
    check(32'(conv_n - b), 32'h0000_0000);
    press(0);
    wait_stat(10'h060);
    check(32'(conv_n - b), 32'h0000_0006);
    check(32'(conv_gap), 32'h0000_0010);
    check(32'(u_adccs_host_model.nwords), 32'h0000_0002);
    check(word(0), wexp(0, 3'b000, 3));
    check(word(1), wexp(3, 3'b000, 3));
    // manual reset mode ignores the gate; button resets
    pulse_listen();
    repeat (100) @(negedge core_clk_i);
    wait_stat(10'h060);
    // auto start, still manual reset so the button below acts
    wr_reg(adccs_pkg::OFF_CTRL, 32'h0000_0013);
    wr_reg(adccs_pkg::OFF_LIMIT, 32'h0000_0007);
    press(1);
    wait_stat(10'h044);
    late <= 1'b1;
    press(2);
    wait_words(3);
    late <= 1'b0;
    wait_stat(10'h260);
    wr_reg(adccs_pkg::OFF_CTRL, 32'h0000_0033);
    check(word(2), wexp(0, 3'b000, 3));
    check(word(3), wexp(3, 3'b111, 3));
    check(word(4), wexp(6, 3'b111, 1));
    check(32'(u_adccs_host_model.bad_n), 32'h0000_0002);
    // auto reset through the gate clears the sticky error
    pulse_listen();
    wait_stat(10'h044);
    press(2);
    wait_words(6);
    mute <= 1'b1;
    wait_stat(10'h060);
    repeat (2) @(negedge core_clk_i);
    check(32'(offer), 32'h0000_0000);
    check(32'(hi_c >= 200 && hi_c <= 204), 32'h0000_0001);
    check(32'(u_adccs_host_model.nwords), 32'h0000_0006);
    mute <= 1'b0;
    // host ends a long run early
    wr_reg(adccs_pkg::OFF_LIMIT, 32'h0000_0300);
    pulse_listen();
    wait_stat(10'h044);
    b = conv_n;
    press(2);
    for (int i = 0; i < 2000 && conv_n < b + 4; i++)
      @(posedge core_clk_i);
    wr_reg(adccs_pkg::OFF_CTRL, 32'h0000_0073);
    wait_stat(10'h060);
    b = conv_n;
    repeat (100) @(negedge core_clk_i);
    check(32'(conv_n - b), 32'h0000_0000);
    final_report();
  end
endmodule
